// *** ocs_pkg.sv ***
// ocs_pkg.sv: constants and types for the oscillator source and status block
package ocs_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] ADDR_CFG = 4'h0;       // source config, drive, clkout
    localparam logic [3:0] ADDR_FREQ = 4'h1;      // fast_freq_reg
    localparam logic [3:0] ADDR_TRIM = 4'h2;      // fast_trim_reg
    localparam logic [3:0] ADDR_ENABLE = 4'h3;    // manual_osc_enable_reg
    localparam logic [3:0] ADDR_READY = 4'h4;     // osc_ready_reg
    localparam logic [3:0] ADDR_TRIM_NOW = 4'h5;  // live trim applied
    // ****************************************
    // field positions
    // ****************************************
    localparam int CFG_SRC_LO = 0;    // requested_source_sel [2:0]
    localparam int CFG_DIV_LO = 4;    // requested_divider_sel [7:4]
    localparam int CFG_DRIVE = 8;     // secondary_drive_high
    localparam int CFG_CLKOUT = 9;    // clock_out_pin_disable_n
    localparam int CFG_ADC_SEL = 10;  // peripheral selects adc rc
    // ready / enable bit positions (shared layout)
    localparam int B_EXT = 7;
    localparam int B_FAST = 6;
    localparam int B_MED = 5;
    localparam int B_SLOW = 4;
    localparam int B_SEC = 3;
    localparam int B_ADC = 2;
    localparam int B_FIX = 1;
    localparam int B_PLL = 0;
    localparam logic [7:0] ENABLE_MASK = 8'hFC;   // pll and fixed not forceable
    // ****************************************
    // source codes and reset values
    // ****************************************
    localparam logic [2:0] SRC_EXT = 3'h7;
    localparam logic [2:0] SRC_FAST = 3'h6;
    localparam logic [2:0] SRC_SLOW = 3'h5;
    localparam logic [2:0] SRC_SEC = 3'h4;
    localparam logic [2:0] SRC_PLL = 3'h2;
    localparam logic [3:0] FREQ_RESET = 4'h0;
    localparam logic [5:0] TRIM_RESET = 6'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    // ****************************************
    // timing
    // ****************************************
    localparam int STARTUP_PERIODS = 1024;            // edges on secondary_in_pin
    localparam logic [10:0] STARTUP_LAST = 11'h400;
    localparam int LOCK_TIME_NS = 2000;               // fast osc relock time
    localparam int CLK_NS = 100;
    localparam logic [7:0] LOCK_CYCLES = 8'((LOCK_TIME_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SETTLE_CYCLES = 8'h08;     // accuracy settle for others
    localparam logic [3:0] TRIM_STEP_CYCLES = 4'hF;   // gradual trim slew
    localparam logic [1:0] CLKOUT_DIV_LAST = 2'h1;    // toggle every 2 -> /4
    localparam int PLL_READY_DEFAULT = 1;
    // state of the fast oscillator
    typedef enum logic [1:0] {FAST_OFF, FAST_LOCKING, FAST_RUN} ocs_fast_t;
endpackage : ocs_pkg

// *** ocs_core.sv ***
// ocs_core.sv: oscillator source control, trim, derived clock enables and ready status
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RULE1: 1024 secondary input edges before secondary ready
// RULE2: drive bit low power zero, high one
// RULE3: software stops secondary before changing drive
// RULE4: secondary enabled when chosen as system clock
// RULE5: clkout pin gpio or system clock/4
// RULE6: frequency select sets rate, divider postscales
// RULE7: trim six-bit signed, resets zero
// RULE8: trim slews gradually, no done flag
// RULE9: trim never touches slow oscillator
// RULE10: medium clocks fixed, never system clock
// RULE11: fixed 1 MHz clock, never system clock
// RULE12: slow osc system clock and timebase
// RULE13: adc rc on when selected or forced
// RULE14: internal ready flags set once accurate
// RULE15: frequency write clears fast ready, holds output
// RULE16: external, secondary ready after startup count
// RULE17: status reports pll ready
// RULE18: manual enable excludes the pll
// RULE19: internal source becomes system clock
// RULE20: ready flags read-only, clear when off
module ocs_core
    import ocs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // reset-time configuration
    input wire logic [2:0] reset_source_cfg,
    // oscillator pins and helpers
    input wire logic secondary_in_pin,
    input wire logic clock_in_pin,
    input wire logic pll_locked,
    input wire logic adc_selects_rc,
    input wire logic sys_clk_tick,
    // clock out pin
    output logic clock_out_pin_o,
    output logic clock_out_pin_oe,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    // oscillator controls
    output logic secondary_osc_en,
    output logic secondary_drive_high,
    output logic fast_internal_osc_en,
    output logic fast_hold,
    output logic [3:0] fast_freq_field,
    output logic [3:0] fast_postscale,
    output logic [5:0] fast_trim_applied,
    output logic slow_internal_osc_en,
    output logic adc_rc_osc_en,
    output logic external_osc_en,
    output logic [2:0] system_source,
    // derived clock enables from fast oscillator
    input wire logic fast_tick_16mhz_equiv,
    output logic medium_500k_tick,
    output logic medium_31k_tick,
    output logic fixed_1mhz_tick
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic first;                 // first cycle after reset latches straps
        logic [2:0] src;             // requested_source_sel
        logic [3:0] div;             // requested_divider_sel
        logic drive;                 // secondary_drive_high
        logic clkout_n;              // clock_out_pin_disable_n
        logic adc_sel;               // software adc rc selection
        logic [3:0] freq;            // fast_freq_field
        logic [5:0] trim;            // fast_trim_field target
        logic [5:0] trim_now;        // trim currently applied
        logic [3:0] trim_cnt;        // slew pacing
        logic [7:0] enable;          // manual_osc_enable_reg
        ocs_fast_t fast;             // fast osc lock state
        logic [7:0] lock_cnt;        // fast relock timer
        logic [10:0] sec_cnt;        // secondary startup_counter
        logic [10:0] ext_cnt;        // external startup_counter
        logic sec_prev;              // previous secondary pin level
        logic ext_prev;              // previous clock in level
        logic [7:0] settle;          // others settle timer
        logic [7:0] ready;           // osc_ready_reg
        logic [4:0] med_div;         // medium 500k divider
        logic [4:0] m31_div;         // 31.25k divider off 500k
        logic [3:0] fix_div;         // 1 MHz divider
        logic [1:0] co_div;          // clkout divider
        logic clkout;                // clkout level
        logic [15:0] rdata;          // read data register
    } ocs_state_t;
    ocs_state_t r;
    ocs_state_t next_r;
    // derived enables
    logic sec_on;
    logic ext_on;
    logic fast_on;
    logic slow_on;
    logic adc_on;
    logic internal_src;
    // ****************************************
    // combinational next state
    // ****************************************
    always_comb begin
        next_r = r;
        // strap capture after release, never inside reset
        if (r.first) begin
            next_r.first = 1'b0;
            next_r.src = reset_source_cfg;                 // [RULE4] [RULE19]
        end
        // who is on
        sec_on = (r.src == SRC_SEC) || r.enable[B_SEC];   // [RULE4]
        ext_on = (r.src == SRC_EXT) || (r.src == SRC_PLL) || r.enable[B_EXT];
        // medium and fixed clocks need the fast oscillator running
        fast_on = (r.src == SRC_FAST) || r.enable[B_FAST] || r.enable[B_MED] || 1'b1;
        slow_on = 1'b1;                                    // watchdog timebase always runs [RULE12]
        adc_on = r.adc_sel || adc_selects_rc || r.enable[B_ADC]; // [RULE13]
        internal_src = (r.src == SRC_FAST) || (r.src == SRC_SLOW);
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CFG: begin
                    next_r.src = reg_wdata[CFG_SRC_LO +: 3];      // [RULE19]
                    next_r.div = reg_wdata[CFG_DIV_LO +: 4];      // [RULE6]
                    // drive only taken while secondary is off [RULE3]
                    if (!sec_on)
                        next_r.drive = reg_wdata[CFG_DRIVE];       // [RULE2]
                    next_r.clkout_n = reg_wdata[CFG_CLKOUT];
                    next_r.adc_sel = reg_wdata[CFG_ADC_SEL];
                end
                ADDR_FREQ: begin
                    next_r.freq = reg_wdata[3:0];                  // [RULE6]
                    next_r.fast = FAST_LOCKING;                    // [RULE15]
                    next_r.lock_cnt = LOCK_CYCLES;
                end
                ADDR_TRIM: begin
                    next_r.trim = reg_wdata[5:0];                  // [RULE7]
                end
                ADDR_ENABLE: begin
                    next_r.enable = reg_wdata[7:0] & ENABLE_MASK;  // [RULE18]
                end
                default: begin
                    // ready register and unmapped are read-only [RULE20]
                end
            endcase
        end
        // trim slews one lsb at a time, only fast oscillator sees it
        if (r.trim_now != r.trim) begin                            // [RULE8] [RULE9]
            if (r.trim_cnt == TRIM_STEP_CYCLES) begin
                next_r.trim_cnt = 4'h0;
                if ($signed(r.trim) > $signed(r.trim_now))
                    next_r.trim_now = r.trim_now + 6'h01;
                else
                    next_r.trim_now = r.trim_now - 6'h01;
            end else begin
                next_r.trim_cnt = r.trim_cnt + 4'h1;
            end
        end else begin
            next_r.trim_cnt = 4'h0;
        end
        // fast oscillator lock sequence
        case (r.fast)
            FAST_OFF: begin
                if (fast_on) begin
                    next_r.fast = FAST_LOCKING;
                    next_r.lock_cnt = LOCK_CYCLES;
                end
            end
            FAST_LOCKING: begin
                if (!(reg_wr && reg_addr == ADDR_FREQ)) begin
                    if (r.lock_cnt <= 8'h01)
                        next_r.fast = FAST_RUN;                    // [RULE15]
                    else
                        next_r.lock_cnt = r.lock_cnt - 8'h01;
                end
            end
            FAST_RUN: begin
            end
            default: next_r.fast = FAST_OFF;
        endcase
        // settle timer for slow/medium/fixed/adc accuracy
        if (r.settle != SETTLE_CYCLES)
            next_r.settle = r.settle + 8'h01;
        // secondary startup count on rising pin edges
        next_r.sec_prev = secondary_in_pin;
        if (!sec_on)
            next_r.sec_cnt = 11'h000;
        else if (secondary_in_pin && !r.sec_prev && r.sec_cnt != STARTUP_LAST)
            next_r.sec_cnt = r.sec_cnt + 11'h001;                  // [RULE1]
        next_r.ext_prev = clock_in_pin;
        if (!ext_on)
            next_r.ext_cnt = 11'h000;
        else if (clock_in_pin && !r.ext_prev && r.ext_cnt != STARTUP_LAST)
            next_r.ext_cnt = r.ext_cnt + 11'h001;
        // ready flags, cleared when source is off
        next_r.ready[B_SEC] = sec_on && (r.sec_cnt == STARTUP_LAST);       // [RULE1] [RULE16] [RULE20]
        next_r.ready[B_EXT] = ext_on && (r.ext_cnt == STARTUP_LAST);       // [RULE16] [RULE20]
        next_r.ready[B_FAST] = (next_r.fast == FAST_RUN);                  // [RULE14] [RULE15]
        next_r.ready[B_MED] = (r.fast == FAST_RUN) && (r.settle == SETTLE_CYCLES); // [RULE14]
        next_r.ready[B_FIX] = (r.fast == FAST_RUN) && (r.settle == SETTLE_CYCLES); // [RULE14]
        next_r.ready[B_SLOW] = slow_on && (r.settle == SETTLE_CYCLES);     // [RULE14]
        next_r.ready[B_ADC] = adc_on && (r.settle == SETTLE_CYCLES);       // [RULE14] [RULE20]
        next_r.ready[B_PLL] = (r.src == SRC_PLL) && pll_locked && r.ready[B_EXT]; // [RULE17]
        // derived fixed clocks from a 16 MHz-equivalent fast tick
        if (fast_tick_16mhz_equiv && r.fast == FAST_RUN) begin     // [RULE10] [RULE11]
            next_r.med_div = r.med_div + 5'h01;                    // /32 -> 500 kHz
            next_r.fix_div = r.fix_div + 4'h1;                     // /16 -> 1 MHz
            // wrap after 16 pulses: a free 5-bit count would halve the rate
            if (r.med_div == 5'h1F && r.m31_div == 5'h0F)
                next_r.m31_div = 5'h00;                            // /16 -> 31.25 kHz
            else if (r.med_div == 5'h1F)
                next_r.m31_div = r.m31_div + 5'h01;
        end
        // clkout: system clock divided by 4
        if (sys_clk_tick) begin                                    // [RULE5]
            if (r.co_div == CLKOUT_DIV_LAST) begin
                next_r.co_div = 2'h0;
                next_r.clkout = ~r.clkout;
            end else begin
                next_r.co_div = r.co_div + 2'h1;
            end
        end
        // read data, one cycle after strobe
        next_r.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CFG: next_r.rdata = {5'h00, r.adc_sel, r.clkout_n, r.drive, r.div, 1'b0, r.src};
                ADDR_FREQ: next_r.rdata = {12'h000, r.freq};
                ADDR_TRIM: next_r.rdata = {10'h000, r.trim};
                ADDR_ENABLE: next_r.rdata = {8'h00, r.enable};
                ADDR_READY: next_r.rdata = {8'h00, r.ready};       // [RULE17]
                ADDR_TRIM_NOW: next_r.rdata = {10'h000, r.trim_now};
                default: next_r.rdata = 16'h0000;
            endcase
        end
    end
    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            r <= '0;
            r.first <= 1'b1;
            r.freq <= FREQ_RESET;
            r.trim <= TRIM_RESET;          // nominal frequency [RULE7]
            r.trim_now <= TRIM_RESET;
            r.enable <= ENABLE_RESET;
            r.clkout_n <= 1'b1;
            r.fast <= FAST_OFF;
        end else begin
            r <= next_r;
        end
    end
    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata = r.rdata;
    assign secondary_osc_en = sec_on;
    assign secondary_drive_high = r.drive;          // [RULE2]
    assign fast_internal_osc_en = (r.fast != FAST_OFF);
    assign fast_hold = (r.fast == FAST_LOCKING);    // output held static [RULE15]
    assign fast_freq_field = r.freq;
    assign fast_postscale = r.div;                  // [RULE6]
    assign fast_trim_applied = r.trim_now;          // [RULE9]
    assign slow_internal_osc_en = slow_on;
    assign adc_rc_osc_en = adc_on;
    assign external_osc_en = ext_on;
    assign system_source = r.src;
    assign medium_500k_tick = fast_tick_16mhz_equiv && (r.fast == FAST_RUN) && (r.med_div == 5'h1F);
    assign medium_31k_tick = medium_500k_tick && (r.m31_div == 5'h0F);
    assign fixed_1mhz_tick = fast_tick_16mhz_equiv && (r.fast == FAST_RUN) && (r.fix_div == 4'hF);
    // clkout pin: gpio when disabled or external source [RULE5]
    assign clock_out_pin_o = (internal_src && !r.clkout_n) ? r.clkout : gpio_out;
    assign clock_out_pin_oe = (internal_src && !r.clkout_n) ? 1'b1 : gpio_oe;
    // ****************************************
    // assertions
    // ****************************************
    a_sec_ready_count: assert property (@(posedge core_clk) disable iff (!resetn)
        r.ready[B_SEC] |-> r.sec_cnt == STARTUP_LAST) else $error("secondary ready early"); // [RULE1]
    a_freq_clears: assert property (@(posedge core_clk) disable iff (!resetn)
        reg_wr && reg_addr == ADDR_FREQ |=> !r.ready[B_FAST] && fast_hold) else $error("fast ready kept"); // [RULE15]
    a_pll_not_forced: assert property (@(posedge core_clk) disable iff (!resetn)
        !r.enable[B_PLL]) else $error("pll force bit set"); // [RULE18]
    a_sec_off_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        !sec_on |=> !r.ready[B_SEC]) else $error("secondary ready while off"); // [RULE20]
    a_adc_auto_on: assert property (@(posedge core_clk) disable iff (!resetn)
        adc_selects_rc |-> adc_rc_osc_en) else $error("adc rc not on"); // [RULE13]
    a_trim_step: assert property (@(posedge core_clk) disable iff (!resetn)
        r.trim_now != $past(r.trim_now) |-> (r.trim_now - $past(r.trim_now) == 6'h01)
        || ($past(r.trim_now) - r.trim_now == 6'h01)) else $error("trim jumped"); // [RULE8]
    a_drive_stable: assert property (@(posedge core_clk) disable iff (!resetn)
        sec_on && $past(sec_on) |-> $stable(r.drive)) else $error("drive changed while running"); // [RULE3]
    a_sec_chosen: assert property (@(posedge core_clk) disable iff (!resetn)
        r.src == SRC_SEC |-> secondary_osc_en) else $error("secondary not enabled"); // [RULE4]
endmodule : ocs_core
`default_nettype wire

// *** ocs_xtal_model.sv ***
// ocs_xtal_model.sv: crystal and external clock source model for the oscillator pins
`timescale 1ns/1ns
`default_nettype none
module ocs_xtal_model (
    // clock
    input wire logic core_clk,
    // enables from the block
    input wire logic sec_en,
    input wire logic ext_en,
    // oscillator pins
    output logic secondary_in_pin,
    output logic clock_in_pin,
    // rising edges since enable, for the bench
    output int sec_edges,
    output int ext_edges
);
    logic [2:0] sec_div; // half period of 8 core cycles
    logic [1:0] ext_div; // faster external source
    // ****************************************
    // sources
    // ****************************************
    // a stopped crystal stands still low, so no stray edge is counted
    always @(posedge core_clk) begin
        if (!sec_en) begin
            sec_div <= 3'h0;
            secondary_in_pin <= 1'b0;
            sec_edges <= 0;
        end else begin
            sec_div <= sec_div + 3'h1;
            if (sec_div == 3'h7) begin
                secondary_in_pin <= ~secondary_in_pin;
                if (!secondary_in_pin) sec_edges <= sec_edges + 1;
            end
        end
        if (!ext_en) begin
            ext_div <= 2'h0;
            clock_in_pin <= 1'b0;
            ext_edges <= 0;
        end else begin
            ext_div <= ext_div + 2'h1;
            if (ext_div == 2'h3) begin
                clock_in_pin <= ~clock_in_pin;
                if (!clock_in_pin) ext_edges <= ext_edges + 1;
            end
        end
    end
endmodule : ocs_xtal_model
`default_nettype wire

// *** tb.sv ***
// tb.sv: self-checking testbench for the oscillator source and status block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ocs_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, pll_locked = 1'b1, adc_sel = 1'b0;
    logic sys_tick = 1'b1, fast_tick = 1'b1, gpio_out = 1'b1, gpio_oe = 1'b0;
    logic [15:0] reg_rdata, rd_val;
    wire logic sec_pin, ext_pin, cko, cko_oe, sec_en, drive, fast_en, hold, slow_en, adc_en, ext_en;
    wire logic m500, m31, f1m;
    wire logic [3:0] freq, post;
    wire logic [5:0] trim_now;
    wire logic [2:0] sys_src;
    int sec_edges, ext_edges, err_count = 0, cmp_count = 0, n500, n31, n1m, ntog;
    logic prev_cko;
    logic [2:0] strap = SRC_FAST; // reset-time source configuration
    always #50 core_clk = ~core_clk; // 10 MHz
    ocs_core u_ocs_core (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_source_cfg(strap),
        .secondary_in_pin(sec_pin), .clock_in_pin(ext_pin), .pll_locked(pll_locked), .adc_selects_rc(adc_sel),
        .sys_clk_tick(sys_tick), .clock_out_pin_o(cko), .clock_out_pin_oe(cko_oe), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .secondary_osc_en(sec_en), .secondary_drive_high(drive), .fast_internal_osc_en(fast_en),
        .fast_hold(hold), .fast_freq_field(freq), .fast_postscale(post), .fast_trim_applied(trim_now),
        .slow_internal_osc_en(slow_en), .adc_rc_osc_en(adc_en), .external_osc_en(ext_en), .system_source(sys_src),
        .fast_tick_16mhz_equiv(fast_tick), .medium_500k_tick(m500), .medium_31k_tick(m31), .fixed_1mhz_tick(f1m));
    ocs_xtal_model u_ocs_xtal_model (.core_clk(core_clk), .sec_en(sec_en), .ext_en(ext_en),
        .secondary_in_pin(sec_pin), .clock_in_pin(ext_pin), .sec_edges(sec_edges), .ext_edges(ext_edges));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask : rd
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic conclude();
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // watchdog: whole run is about 26k cycles
    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        conclude();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        step(2);
        resetn <= 1'b1;
        step(30); // let every internal source settle and lock
        chk(16'(sys_src), 16'(SRC_FAST));
        rd(ADDR_TRIM); chk(rd_val, 16'h0000);
        rd(ADDR_ENABLE); chk(rd_val, 16'h0000);
        // pll ready stays low while the pll is not the chosen source
        rd(ADDR_READY); chk(rd_val, 16'h0072);
        pll_locked <= 1'b0;
        rd(ADDR_READY); chk(rd_val, 16'h0072);
        pll_locked <= 1'b1;
        wr(ADDR_READY, 16'hFFFF); // status must ignore software
        rd(ADDR_READY); chk(rd_val, 16'h0072);
        chk({15'h0, cko_oe}, {15'h0, gpio_oe});
        chk({15'h0, cko}, {15'h0, gpio_out});
        // drive changes only while the secondary is stopped
        wr(ADDR_CFG, 16'h0306); step(1); chk({15'h0, drive}, 16'h0001);
        wr(ADDR_CFG, 16'h0206); step(1); chk({15'h0, drive}, 16'h0000);
        // frequency change drops fast ready and freezes the output
        wr(ADDR_FREQ, 16'h0003); chk({15'h0, hold}, 16'h0001);
        // medium and fixed ready follow the stalled fast oscillator
        rd(ADDR_READY); chk(rd_val, 16'h0010);
        step(25);
        rd(ADDR_READY); chk(rd_val, 16'h0072);
        chk(16'(freq), 16'h0003);
        wr(4'hF, 16'hFFFF); // unmapped place must not alias
        rd(ADDR_FREQ); chk(rd_val, 16'h0003);
        // trim slews gradually up, then down to a negative value
        wr(ADDR_TRIM, 16'h0004); step(20);
        chk({15'h0, trim_now == 6'h04}, 16'h0000);
        step(80);
        rd(ADDR_TRIM_NOW); chk(rd_val, 16'h0004);
        chk({15'h0, slow_en}, 16'h0001);
        wr(ADDR_TRIM, 16'h003E); step(120);
        rd(ADDR_TRIM_NOW); chk(rd_val, 16'h003E);
        rd(ADDR_READY); chk(rd_val, 16'h0072);
        // clock out on, postscale 5, then count derived ticks
        wr(ADDR_CFG, 16'h0056); step(2);
        chk(16'(post), 16'h0005);
        chk({15'h0, cko_oe}, 16'h0001);
        n500 = 0; n31 = 0; n1m = 0; ntog = 0; prev_cko = cko;
        for (int i = 0; i < 512; i++) begin
            step(1);
            n500 += int'(m500);
            n31 += int'(m31);
            n1m += int'(f1m);
            if (cko !== prev_cko) ntog++;
            prev_cko = cko;
        end
        chk(16'(n500), 16'd16);
        chk(16'(n31), 16'd1);
        chk(16'(n1m), 16'd32);
        chk(16'(ntog), 16'd256);
        chk(16'(sys_src), 16'(SRC_FAST));
        // secondary as system clock: ready only after 1024 edges
        wr(ADDR_CFG, 16'h0004); step(2);
        chk({15'h0, sec_en}, 16'h0001);
        chk({15'h0, cko_oe}, {15'h0, gpio_oe});
        for (int i = 0; i < 20000 && sec_edges < 1023; i++) step(1);
        rd(ADDR_READY); chk(rd_val, 16'h0072);
        for (int i = 0; i < 40 && sec_edges < 1024; i++) step(1);
        step(4);
        rd(ADDR_READY); chk(rd_val, 16'h007A);
        // drive write refused while the secondary runs
        wr(ADDR_CFG, 16'h0304); step(1); chk({15'h0, drive}, 16'h0000);
        wr(ADDR_CFG, 16'h0006); step(2);
        rd(ADDR_READY); chk(rd_val, 16'h0072);
        // manual enable, pll and fixed bits masked
        wr(ADDR_ENABLE, 16'h00FF);
        rd(ADDR_ENABLE); chk(rd_val, 16'h00FC);
        chk({14'h0, ext_en, adc_en}, 16'h0003);
        wr(ADDR_ENABLE, 16'h0000); step(2);
        chk({15'h0, adc_en}, 16'h0000);
        adc_sel <= 1'b1; step(2);
        chk({15'h0, adc_en}, 16'h0001);
        adc_sel <= 1'b0; step(2);
        chk({15'h0, adc_en}, 16'h0000);
        wr(ADDR_CFG, 16'h0406); step(1);
        chk({15'h0, adc_en}, 16'h0001);
        // pll chosen: external start-up count, then pll ready
        wr(ADDR_CFG, 16'h0202);
        for (int i = 0; i < 20000 && ext_edges < 1024; i++) step(1);
        step(6);
        rd(ADDR_READY); chk(rd_val, 16'h00F3);
        pll_locked <= 1'b0;
        rd(ADDR_READY); chk(rd_val, 16'h00F2);
        pll_locked <= 1'b1;
        wr(ADDR_CFG, 16'h0206); step(2);
        rd(ADDR_READY); chk(rd_val, 16'h0072);
        // second reset with the secondary strapped as source
        strap <= SRC_SEC;
        resetn <= 1'b0; step(2);
        resetn <= 1'b1; step(2);
        chk(16'(sys_src), 16'(SRC_SEC));
        chk({15'h0, sec_en}, 16'h0001);
        conclude();
    end
endmodule : tb
`default_nettype wire
